// File: design/pers_pkg.sv
package pers_pkg;
  localparam logic [11:0] PERS_AER_BASE = 12'h100;
  localparam logic [11:0] PERS_DSN_BASE = 12'h140;
  localparam logic [11:0] PERS_NEXT_NONE = 12'h000;
  localparam logic [7:0] PERS_OFS_HDR = 8'h00;
  localparam logic [7:0] PERS_OFS_UNC_STS = 8'h04;
  localparam logic [7:0] PERS_OFS_UNC_MSK = 8'h08;
  localparam logic [7:0] PERS_OFS_UNC_SEV = 8'h0c;
  localparam logic [7:0] PERS_OFS_COR_STS = 8'h10;
  localparam logic [7:0] PERS_OFS_COR_MSK = 8'h14;
  localparam logic [7:0] PERS_OFS_FEP = 8'h18;
  localparam logic [7:0] PERS_OFS_HLOG0 = 8'h1c;
  localparam logic [7:0] PERS_OFS_HLOG3 = 8'h28;
  localparam logic [7:0] PERS_OFS_SN_LO = 8'h04;
  localparam logic [7:0] PERS_OFS_SN_HI = 8'h08;
  localparam logic [15:0] PERS_AER_CAP_ID = 16'h0001;
  localparam logic [15:0] PERS_DSN_CAP_ID = 16'h0003;
  localparam logic [3:0] PERS_CAP_VER = 4'h1;
  localparam int PERS_NEXT_LSB = 20;
  localparam int PERS_VER_LSB = 16;
  // Implemented bits: DLP 4, poison 12..UR 20 except 19
  localparam logic [31:0] PERS_UNC_IMPL = 32'h0017_f010;
  localparam logic [31:0] PERS_UNC_SEV_RST = 32'h0006_2010;
  // Correctable: 0, 6, 7, 8, 12, 13
  localparam logic [15:0] PERS_COR_IMPL = 16'h31c1;
  localparam logic [15:0] PERS_COR_MSK_RST = 16'h2000;
  localparam logic [2:0] PERS_FUNC0 = 3'h0;
endpackage

// File: design/pers_regs.sv
// Overview of operation
// - Uncorrectable status bits 4 and 12-18, 20 set by their error sources.
// - Writing one clears an implemented status bit; status resets to zero.
// - Uncorrectable mask, one bit per status bit, blocks error message.
// - Severity one reports fatal, zero reports non-fatal.
// - Severity resets one at 4, 13, 17, 18; only implemented severity bits writable.
// - Correctable status bits 0, 6, 7, 8, 12, 13 set by sources.
// - Correctable mask, one bit per status bit, blocks error message.
// - Advisory non-fatal mask resets to one, other masks zero.
// - Read-only first-error pointer in bits 3:0, reset zero.
// - Read-only 128-bit header log of offending packet, reset zero.
// - Read-only 64-bit unique serial number.
// - Serial capability is header, serial low dword, serial high dword.
// - Header holds next offset 31:20, version 19:16, ID 0003h.
// - Serial capability decoded for function 0 only.
// - Error capability at 0x100, serial capability at 0x140.
// - Error header next pointer 0x140 if serial enabled, else 0x000.
`timescale 1ns/100ps
`default_nettype none
module pers_regs
  import pers_pkg::*;
#(
  parameter logic [63:0] SERIAL_NUMBER = 64'h0123_4567_89ab_cdef // Arbitrary value
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic STICKY_RESET_I,
  input wire logic SERIAL_CAP_EN_I,
  input wire logic CFG_RD_I,
  input wire logic CFG_WR_I,
  input wire logic [2:0] CFG_FUNC_I,
  input wire logic [11:0] CFG_ADDR_I,
  input wire logic [31:0] CFG_WDATA_I,
  input wire logic [3:0] CFG_BE_I,
  input wire logic [31:0] UNC_ERR_I,
  input wire logic [15:0] COR_ERR_I,
  input wire logic [127:0] ERR_HDR_I,
  output logic [31:0] CFG_RDATA_O,
  output logic CFG_RVALID_O,
  output logic UNC_REPORT_O,
  output logic UNC_FATAL_O,
  output logic COR_REPORT_O
);
  logic [7:0] ofs;
  logic aer_hit;
  logic dsn_hit;
  logic wr_unc_sts;
  logic wr_unc_msk;
  logic wr_unc_sev;
  logic wr_cor_sts;
  logic wr_cor_msk;
  logic [31:0] wmask;
  logic [31:0] wr_bits;
  logic [31:0] unc_new;
  logic [15:0] cor_new;
  logic [3:0] first_bit;
  logic [1:0] hlog_sel;
  logic [31:0] unc_sts_q;
  logic [31:0] unc_sts_d;
  logic [31:0] unc_msk_q;
  logic [31:0] unc_msk_d;
  logic [31:0] unc_sev_q;
  logic [31:0] unc_sev_d;
  logic [15:0] cor_sts_q;
  logic [15:0] cor_sts_d;
  logic [15:0] cor_msk_q;
  logic [15:0] cor_msk_d;
  logic [3:0] fep_q;
  logic [3:0] fep_d;
  logic [127:0] hlog_q;
  logic [127:0] hlog_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic unc_rep_q;
  logic unc_rep_d;
  logic unc_fat_q;
  logic unc_fat_d;
  logic cor_rep_q;
  logic cor_rep_d;

  // Dword decode; address bits 1:0 select nothing
  always_comb begin
    ofs = {2'b00, CFG_ADDR_I[5:2], 2'b00};
    aer_hit = 1'b0;
    dsn_hit = 1'b0;
    if (CFG_FUNC_I == PERS_FUNC0) begin
      if (CFG_ADDR_I[11:6] == PERS_AER_BASE[11:6]) begin
        aer_hit = 1'b1;
      end
      if (CFG_ADDR_I[11:6] == PERS_DSN_BASE[11:6] && SERIAL_CAP_EN_I) begin
        dsn_hit = 1'b1;
      end
    end
  end

  for (genvar b = 0; b < 4; b++) begin : g_be
    assign wmask[8*b +: 8] = {8{CFG_BE_I[b]}};
  end
  assign wr_bits = CFG_WDATA_I & wmask;
  assign unc_new = UNC_ERR_I & PERS_UNC_IMPL;
  assign cor_new = COR_ERR_I & PERS_COR_IMPL;

  always_comb begin
    wr_unc_sts = 1'b0;
    wr_unc_msk = 1'b0;
    wr_unc_sev = 1'b0;
    wr_cor_sts = 1'b0;
    wr_cor_msk = 1'b0;
    if (CFG_WR_I && aer_hit) begin
      case (ofs)
        PERS_OFS_UNC_STS: begin
          wr_unc_sts = 1'b1;
        end
        PERS_OFS_UNC_MSK: begin
          wr_unc_msk = 1'b1;
        end
        PERS_OFS_UNC_SEV: begin
          wr_unc_sev = 1'b1;
        end
        PERS_OFS_COR_STS: begin
          wr_cor_sts = 1'b1;
        end
        PERS_OFS_COR_MSK: begin
          wr_cor_msk = 1'b1;
        end
        // Read-only and unmapped offsets drop the write
        default: begin
        end
      endcase
    end
  end

  // A new event wins over a same-cycle clear, so no error is lost
  always_comb begin
    unc_sts_d = unc_sts_q;
    unc_msk_d = unc_msk_q;
    unc_sev_d = unc_sev_q;
    if (wr_unc_sts) begin
      unc_sts_d = unc_sts_q & ~wr_bits;
    end
    if (wr_unc_msk) begin
      unc_msk_d = ((unc_msk_q & ~wmask) | wr_bits) & PERS_UNC_IMPL;
    end
    if (wr_unc_sev) begin
      unc_sev_d = ((unc_sev_q & ~wmask) | wr_bits) & PERS_UNC_IMPL;
    end
    unc_sts_d = (unc_sts_d | unc_new) & PERS_UNC_IMPL;
  end

  // Sticky state only follows the power-on reset
  always_ff @(posedge CORE_CLK_I or posedge STICKY_RESET_I) begin
    if (STICKY_RESET_I) begin
      unc_sts_q <= 32'h0000_0000;
      unc_msk_q <= 32'h0000_0000;
      unc_sev_q <= PERS_UNC_SEV_RST;
    end else begin
      unc_sts_q <= unc_sts_d;
      unc_msk_q <= unc_msk_d;
      unc_sev_q <= unc_sev_d;
    end
  end

  always_comb begin
    cor_sts_d = cor_sts_q;
    cor_msk_d = cor_msk_q;
    if (wr_cor_sts) begin
      cor_sts_d = cor_sts_q & ~wr_bits[15:0];
    end
    if (wr_cor_msk) begin
      cor_msk_d = ((cor_msk_q & ~wmask[15:0]) | wr_bits[15:0]) & PERS_COR_IMPL;
    end
    cor_sts_d = (cor_sts_d | cor_new) & PERS_COR_IMPL;
  end

  always_ff @(posedge CORE_CLK_I or posedge STICKY_RESET_I) begin
    if (STICKY_RESET_I) begin
      cor_sts_q <= 16'h0000;
      cor_msk_q <= PERS_COR_MSK_RST;
    end else begin
      cor_sts_q <= cor_sts_d;
      cor_msk_q <= cor_msk_d;
    end
  end

  // Lowest new bit wins; the 4-bit field keeps only low bits of 16..20
  always_comb begin
    first_bit = 4'h0;
    for (int i = 31; i >= 0; i--) begin
      if (unc_new[i]) begin
        first_bit = i[3:0];
      end
    end
  end

  always_comb begin
    fep_d = fep_q;
    hlog_d = hlog_q;
    if (unc_new != 32'h0000_0000 && unc_sts_q == 32'h0000_0000) begin
      fep_d = first_bit;
      hlog_d = ERR_HDR_I;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge STICKY_RESET_I) begin
    if (STICKY_RESET_I) begin
      fep_q <= 4'h0;
      hlog_q <= '0;
    end else begin
      fep_q <= fep_d;
      hlog_q <= hlog_d;
    end
  end

  // Reports use the mask as it stood before any same-cycle write
  always_comb begin
    unc_rep_d = |(unc_new & ~unc_msk_q);
    unc_fat_d = |(unc_new & ~unc_msk_q & unc_sev_q);
    cor_rep_d = |(cor_new & ~cor_msk_q);
  end

  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      unc_rep_q <= 1'b0;
      unc_fat_q <= 1'b0;
      cor_rep_q <= 1'b0;
    end else begin
      unc_rep_q <= unc_rep_d;
      unc_fat_q <= unc_fat_d;
      cor_rep_q <= cor_rep_d;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    rvalid_d = CFG_RD_I;
    hlog_sel = ofs[3:2] + 2'h1;
    if (CFG_RD_I && aer_hit) begin
      case (ofs)
        PERS_OFS_HDR: begin
          rdata_d = {SERIAL_CAP_EN_I ? PERS_DSN_BASE : PERS_NEXT_NONE,
                     PERS_CAP_VER, PERS_AER_CAP_ID};
        end
        PERS_OFS_UNC_STS: begin
          rdata_d = unc_sts_q;
        end
        PERS_OFS_UNC_MSK: begin
          rdata_d = unc_msk_q;
        end
        PERS_OFS_UNC_SEV: begin
          rdata_d = unc_sev_q;
        end
        PERS_OFS_COR_STS: begin
          rdata_d = {16'h0000, cor_sts_q};
        end
        PERS_OFS_COR_MSK: begin
          rdata_d = {16'h0000, cor_msk_q};
        end
        PERS_OFS_FEP: begin
          rdata_d = {28'h000_0000, fep_q};
        end
        default: begin
          // Log dwords start at the last slot of a 16-byte row
          if (ofs >= PERS_OFS_HLOG0 && ofs <= PERS_OFS_HLOG3) begin
            case (hlog_sel)
              2'h0: rdata_d = hlog_q[31:0];
              2'h1: rdata_d = hlog_q[63:32];
              2'h2: rdata_d = hlog_q[95:64];
              2'h3: rdata_d = hlog_q[127:96];
              default: rdata_d = 32'h0000_0000;
            endcase
          end
        end
      endcase
    end else if (CFG_RD_I && dsn_hit) begin
      case (ofs)
        PERS_OFS_HDR: begin
          rdata_d = {PERS_NEXT_NONE, PERS_CAP_VER, PERS_DSN_CAP_ID};
        end
        PERS_OFS_SN_LO: begin
          rdata_d = SERIAL_NUMBER[31:0];
        end
        PERS_OFS_SN_HI: begin
          rdata_d = SERIAL_NUMBER[63:32];
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign CFG_RDATA_O = rdata_q;
  assign CFG_RVALID_O = rvalid_q;
  assign UNC_REPORT_O = unc_rep_q;
  assign UNC_FATAL_O = unc_fat_q;
  assign COR_REPORT_O = cor_rep_q;
endmodule
`default_nettype wire

// File: testbench/pers_host.sv
`timescale 1ns/100ps
`default_nettype none
module pers_host (
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i,
  output logic rd_o,
  output logic wr_o,
  output logic [2:0] func_o,
  output logic [11:0] addr_o,
  output logic [31:0] wdata_o
);
  initial {rd_o, wr_o, func_o, addr_o, wdata_o} = '0;
  // Held over one rising edge; on release strobes drop and address and data invert so stale values never match
  task automatic acc(input logic w, input logic [2:0] f, input logic [11:0] a,
    input logic [31:0] d, output logic [32:0] r);
    @(negedge clk_i);
    {rd_o, wr_o, func_o, addr_o, wdata_o} = {~w, w, f, a, d};
    @(negedge clk_i);
    r = {rvalid_i, rdata_i};
    {rd_o, wr_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// File: testbench/pers_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pers_regs_chk
  import pers_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic STICKY_RESET_I,
  input wire logic SERIAL_CAP_EN_I,
  input wire logic CFG_RD_I,
  input wire logic [2:0] CFG_FUNC_I,
  input wire logic [11:0] CFG_ADDR_I,
  input wire logic [31:0] UNC_ERR_I,
  input wire logic [15:0] COR_ERR_I,
  input wire logic [31:0] CFG_RDATA_O,
  input wire logic CFG_RVALID_O,
  input wire logic UNC_REPORT_O,
  input wire logic UNC_FATAL_O,
  input wire logic COR_REPORT_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I || STICKY_RESET_I);
  sequence s_rd(a);
    CFG_RD_I && CFG_FUNC_I == 3'h0 && CFG_ADDR_I == a;
  endsequence
  a_read_answer: assert property (CFG_RD_I |=> CFG_RVALID_O) else $error("no valid");
  a_idle_quiet: assert property (!CFG_RD_I |=> !CFG_RVALID_O && CFG_RDATA_O == '0)
    else $error("idle read bus");
  a_aer_header: assert property (s_rd(12'h100) |=> CFG_RDATA_O ==
    {($past(SERIAL_CAP_EN_I) ? 12'h140 : 12'h000), 20'h1_0001}) else $error("aer header");
  a_dsn_header: assert property (s_rd(12'h140) ##0 SERIAL_CAP_EN_I |=>
    CFG_RDATA_O == 32'h0001_0003) else $error("serial header");
  a_dsn_off: assert property (s_rd(12'h140) ##0 !SERIAL_CAP_EN_I |=> CFG_RDATA_O == '0)
    else $error("serial cap off");
  a_func_zero: assert property (CFG_RD_I && CFG_FUNC_I != 3'h0 |=> CFG_RDATA_O == '0)
    else $error("function decode");
  a_fatal_sub: assert property (UNC_FATAL_O |-> UNC_REPORT_O) else $error("fatal alone");
  a_unc_cause: assert property (UNC_REPORT_O |-> ($past(UNC_ERR_I) & PERS_UNC_IMPL) != '0)
    else $error("unc report cause");
  a_cor_cause: assert property (COR_REPORT_O |-> ($past(COR_ERR_I) & PERS_COR_IMPL) != '0)
    else $error("cor report cause");
  a_adv_masked: assert property (COR_ERR_I == 16'h2000 |=> !COR_REPORT_O)
    else $error("advisory reported");
endmodule
`default_nettype wire

// File: testbench/tb_pcie_error_report_serial_cap.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pcie_error_report_serial_cap;
  localparam logic [63:0] SN = 64'h0aa5_5aa5_1234_5678;
  localparam logic [31:0] SEV = 32'h0006_2010;
  logic clk = 1'b0, rst = 1'b1, srst = 1'b1, en = 1'b1, rd, wr, rv, ur, uf, cr;
  logic [2:0] fn;
  logic [11:0] ad;
  logic [31:0] wd, rdat, ue = '0;
  logic [15:0] ce = '0;
  logic [127:0] hd = '0;
  logic [32:0] r;
  int bad_count = 0, comparisons = 0;
  int ub[9] = '{4, 12, 13, 14, 15, 16, 17, 18, 20};
  int cb[6] = '{0, 6, 7, 8, 12, 13};
  always #50 clk = ~clk;
  pers_regs #(.SERIAL_NUMBER(SN)) u_dut (.CORE_CLK_I(clk), .RESET_I(rst),
    .STICKY_RESET_I(srst), .SERIAL_CAP_EN_I(en), .CFG_RD_I(rd), .CFG_WR_I(wr),
    .CFG_FUNC_I(fn), .CFG_ADDR_I(ad), .CFG_WDATA_I(wd), .CFG_BE_I(4'hf),
    .UNC_ERR_I(ue), .COR_ERR_I(ce), .ERR_HDR_I(hd), .CFG_RDATA_O(rdat),
    .CFG_RVALID_O(rv), .UNC_REPORT_O(ur), .UNC_FATAL_O(uf), .COR_REPORT_O(cr));
  pers_host u_host (.clk_i(clk), .rdata_i(rdat), .rvalid_i(rv), .rd_o(rd), .wr_o(wr),
    .func_o(fn), .addr_o(ad), .wdata_o(wd));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    u_host.acc(1'b0, 3'h0, a, '0, r);
    chk(r, {1'b1, e});
  endtask
  task automatic wrt(input logic [11:0] a, input logic [31:0] d);
    u_host.acc(1'b1, 3'h0, a, d, r);
  endtask
  // Reports stand only in the cycle after the pulse
  task automatic pulse(input logic [31:0] u, input logic [15:0] c, input logic [2:0] e);
    @(negedge clk);
    {ue, ce, hd} = {u, c, u + 32'd3, u + 32'd2, u + 32'd1, u};
    @(negedge clk);
    {ue, ce} = '0;
    hd = ~hd;
    chk({ur, uf, cr}, e);
  endtask
  task automatic t_defaults;
    rdc(12'h100, 32'h1401_0001);
    rdc(12'h104, '0);
    rdc(12'h108, '0);
    rdc(12'h10c, SEV);
    rdc(12'h114, 32'h0000_2000);
    rdc(12'h118, '0);
    rdc(12'h11c, '0);
    rdc(12'h140, 32'h0001_0003);
    rdc(12'h144, SN[31:0]);
    rdc(12'h148, SN[63:32]);
    u_host.acc(1'b0, 3'h1, 12'h144, '0, r);
    chk(r, 33'h1_0000_0000);
    $display("defaults done");
  endtask
  task automatic t_errors;
    foreach (ub[i]) pulse(32'h1 << ub[i], '0, {1'b1, SEV[ub[i]], 1'b0});
    rdc(12'h104, 32'h0017_f010);
    rdc(12'h118, 32'h0000_0004);
    rdc(12'h11c, 32'h0000_0010);
    rdc(12'h128, 32'h0000_0013);
    wrt(12'h104, 32'hffff_ffff);
    rdc(12'h104, '0);
    foreach (cb[i]) pulse('0, 16'h1 << cb[i], {2'b00, cb[i] != 13});
    rdc(12'h110, 32'h0000_31c1);
    wrt(12'h110, 32'hffff_ffff);
    rdc(12'h110, '0);
    $display("errors done");
  endtask
  task automatic t_mask;
    wrt(12'h108, 32'hffff_ffff);
    rdc(12'h108, 32'h0017_f010);
    pulse(32'h0010_0000, '0, 3'b000);
    rdc(12'h104, 32'h0010_0000);
    rdc(12'h11c, 32'h0010_0000);
    wrt(12'h10c, 32'hffff_ffff);
    rdc(12'h10c, 32'h0017_f010);
    $display("mask done");
  endtask
  task automatic t_sticky;
    @(negedge clk) rst = 1'b1;
    @(negedge clk) rst = 1'b0;
    rdc(12'h108, 32'h0017_f010);
    en = 1'b0;
    rdc(12'h100, 32'h0001_0001);
    rdc(12'h140, '0);
    $display("sticky done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #300 {rst, srst} = 2'b00;
    t_defaults;
    t_errors;
    t_mask;
    t_sticky;
    finish_test;
  end
  initial begin
    #500_000 bad_count++;
    finish_test;
  end
endmodule
bind pers_regs pers_regs_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I),
  .STICKY_RESET_I(STICKY_RESET_I), .SERIAL_CAP_EN_I(SERIAL_CAP_EN_I), .CFG_RD_I(CFG_RD_I),
  .CFG_FUNC_I(CFG_FUNC_I), .CFG_ADDR_I(CFG_ADDR_I), .UNC_ERR_I(UNC_ERR_I),
  .COR_ERR_I(COR_ERR_I), .CFG_RDATA_O(CFG_RDATA_O), .CFG_RVALID_O(CFG_RVALID_O),
  .UNC_REPORT_O(UNC_REPORT_O), .UNC_FATAL_O(UNC_FATAL_O), .COR_REPORT_O(COR_REPORT_O));
`default_nettype wire
